// >>> nvb_map.svh
// Constants of the non-volatile byte store controller: offsets, bit
// positions, reset values and timing counts.
// Assumes a 25 MHz core clock and a byte-wide special-function bus.
`ifndef NVB_MAP_SVH
`define NVB_MAP_SVH

// Store geometry
`define NVB_DEPTH 64
`define NVB_LAST_INDEX 6'h3F

// Special-function offsets, bank 0 region
`define NVB_OFF_BANK_SELECT 8'h04
`define NVB_OFF_IRQ_CTRL 8'h0E
`define NVB_OFF_BYTE_INDEX 8'h1E
`define NVB_OFF_BYTE_VALUE 8'h1F
// Control register, bank 1 only
`define NVB_OFF_CONTROL 8'h40

// Control register bit positions
`define NVB_CTL_PROG_PERMIT 3
`define NVB_CTL_PROG_GO 2
`define NVB_CTL_FETCH_PERMIT 1
`define NVB_CTL_FETCH_GO 0

// Interrupt control register bit positions
`define NVB_IRQ_MASK 0
`define NVB_IRQ_FLAG 1
`define NVB_IRQ_MF_ENABLE 2
`define NVB_IRQ_MF_FLAG 3

// Bank selector bit position
`define NVB_BANK_BIT 0

// Reset values
`define NVB_RST_BYTE 8'h00
`define NVB_RST_INDEX 6'h00
`define NVB_RST_LFSR 8'h5A

// Timing
`define NVB_CLK_NS 40
`define NVB_WRITE_BASE_NS 4000
`define NVB_READ_CYCLES 4'h2

`endif

// >>> nvb_pkg.sv
// Types shared by the non-volatile byte store controller.
// Assumes nvb_map.svh is compiled alongside.
package nvb_pkg;

    typedef enum logic [1:0] {
        NVB_IDLE = 2'b00,
        NVB_READ = 2'b01,
        NVB_WRITE = 2'b10
    } nvb_state_t;

    // One core data-memory access per cycle
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic indirect;
    } nvb_bus_req_t;

    // Request into the byte store
    typedef struct packed {
        logic wr_en;
        logic [5:0] wr_addr;
        logic [7:0] wr_data;
        logic [5:0] rd_addr;
    } nvb_store_req_t;

endpackage : nvb_pkg

// >>> nvb_store.sv
// 64 x 8 byte store held in flip-flops, registered read port.
// Assumes the caller holds rd_addr steady for one cycle before use.
`timescale 1ns/10ps
`include "nvb_map.svh"

module nvb_store (
    input wire logic ref_clk,
    input wire nvb_pkg::nvb_store_req_t req,
    output logic [7:0] rd_data
);

    // No reset: contents survive, like the cells they model
    logic [7:0] cells [0:`NVB_DEPTH-1];

    always_ff @(posedge ref_clk) begin
        if (req.wr_en) begin
            cells[req.wr_addr] <= req.wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        rd_data <= cells[req.rd_addr];
    end

endmodule : nvb_store

// >>> nvb_wtimer.sv
// Write-cycle timer: base delay plus a pseudo-random extra.
// Assumes start is a one-cycle pulse given only while not running.
`timescale 1ns/10ps
`include "nvb_map.svh"

module nvb_wtimer (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    output logic done
);

    localparam logic [15:0] BASE_CYCLES = 16'((`NVB_WRITE_BASE_NS
        + `NVB_CLK_NS - 1) / `NVB_CLK_NS);

    logic [7:0] lfsr;
    logic [15:0] count;
    logic running;

    // Free-running jitter source stands in for the unsynced oscillator
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lfsr <= `NVB_RST_LFSR;
        end else begin
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count <= 16'h0000;
            running <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count <= BASE_CYCLES + {12'h000, lfsr[3:0]}; // [RULE_13]
                running <= 1'b1;
            end else if (running) begin
                if (count == 16'h0001) begin
                    running <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - 16'h0001;
                end
            end
        end
    end

endmodule : nvb_wtimer

// >>> nvb_ctrl.sv
// Byte access controller for the 64-byte non-volatile store.
// Assumes the core presents one access per cycle on bus_req and that
// the interrupt controller pulses irq_service when it takes the vector.
//
// Operation
// [RULE_01] Store holds 64 bytes at index 00H..3FH; one byte per access.
// [RULE_02] Index register: six read/write bits, top two read zero.
// [RULE_03] Index and value in bank 0; control at 40H, bank 1 only.
// [RULE_04] Control bits: program permit/go at 3/2, fetch permit/go 1/0.
// [RULE_05] Value register holds fetched byte or byte to be stored.
// [RULE_06] Program go is ignored unless program permit is already set.
// [RULE_07] Fetch go is ignored unless fetch permit is already set.
// [RULE_08] Program permit low blocks every write into the store.
// [RULE_09] Fetch permit low blocks every read from the store.
// [RULE_10] Hardware clears program go when the write cycle finishes.
// [RULE_11] Hardware clears fetch go at read end; byte then valid.
// [RULE_12] Fetched byte stays put until another read or write.
// [RULE_13] Write duration comes from a timer unrelated to the clock; here 100 ref_clk cycles plus a 0..15-cycle LFSR extra.
// [RULE_14] Software never sets both go bits, nor all four bits at once.
// [RULE_15] Read: permit, load index, set go, read value after go clears.
// [RULE_16] Write: load index and value, then permit and go back to back.
// [RULE_17] Software masks interrupts globally around write start.
// [RULE_18] Reset clears program permit and selects bank 0.
// [RULE_19] Only write completion raises an interrupt request.
// [RULE_20] Write end sets own done flag and multi-function flag.
// [RULE_21] Vector needs gate, mask, multi-function enable, stack room.
// [RULE_22] Servicing clears only the multi-function flag.
// [RULE_23] Software keeps permit low and bank 0 when idle.
// [RULE_24] Bank selector bit 0 picks bank for indirect accesses.
// [RULE_25] Direct accesses always land in bank 0.
// [RULE_26] Read cycle completes after a fixed small cycle count.
// [RULE_27] Index and value are sampled when a write cycle starts.
`timescale 1ns/10ps
`include "nvb_map.svh"

module nvb_ctrl (
    input wire logic ref_clk,
    input wire logic rst,
    input wire nvb_pkg::nvb_bus_req_t bus_req,
    input wire logic global_irq_gate,
    input wire logic stack_full,
    input wire logic irq_service,
    output logic [7:0] bus_rdata,
    output logic bus_hit,
    output logic irq_vector_req,
    output logic nv_busy
);

    // Address match; control needs bank 1 via the indirect path only
    function automatic logic nvb_sel(
        input logic [7:0] addr,
        input logic indirect,
        input logic bank,
        input logic [7:0] offset,
        input logic want_bank1
    );
        logic eff_bank1;
        eff_bank1 = indirect & bank; // [RULE_24] [RULE_25]
        if (addr != offset) begin
            nvb_sel = 1'b0;
        end else if (want_bank1) begin
            nvb_sel = eff_bank1;
        end else begin
            nvb_sel = 1'b1;
        end
    endfunction : nvb_sel

    nvb_pkg::nvb_state_t state;
    nvb_pkg::nvb_state_t next_state;
    nvb_pkg::nvb_store_req_t store_req;

    logic [5:0] nv_byte_index;
    logic [7:0] nv_byte_value;
    logic ram_bank_select;
    logic program_permit;
    logic prog_go;
    logic fetch_permit;
    logic fetch_go;
    logic nv_done_irq_mask;
    logic nv_done_irq_flag;
    logic mf_irq_enable;
    logic mf_irq_flag;
    logic [3:0] read_cnt;
    logic [5:0] rd_addr;
    logic [5:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] store_rd_data;

    logic sel_index;
    logic sel_value;
    logic sel_bank;
    logic sel_irq;
    logic sel_ctl;
    logic wr_index;
    logic wr_value;
    logic wr_bank;
    logic wr_irq;
    logic wr_ctl;
    logic try_prog;
    logic try_fetch;
    logic start_write;
    logic start_read;
    logic read_done;
    logic write_done;
    logic timer_done;

    assign sel_index = nvb_sel(bus_req.addr, bus_req.indirect,
        ram_bank_select, `NVB_OFF_BYTE_INDEX, 1'b0); // [RULE_03]
    assign sel_value = nvb_sel(bus_req.addr, bus_req.indirect,
        ram_bank_select, `NVB_OFF_BYTE_VALUE, 1'b0); // [RULE_03]
    assign sel_bank = nvb_sel(bus_req.addr, bus_req.indirect,
        ram_bank_select, `NVB_OFF_BANK_SELECT, 1'b0);
    assign sel_irq = nvb_sel(bus_req.addr, bus_req.indirect,
        ram_bank_select, `NVB_OFF_IRQ_CTRL, 1'b0);
    assign sel_ctl = nvb_sel(bus_req.addr, bus_req.indirect,
        ram_bank_select, `NVB_OFF_CONTROL, 1'b1); // [RULE_03]

    assign wr_index = bus_req.wr & sel_index;
    assign wr_value = bus_req.wr & sel_value;
    assign wr_bank = bus_req.wr & sel_bank;
    assign wr_irq = bus_req.wr & sel_irq;
    assign wr_ctl = bus_req.wr & sel_ctl;

    // Go requests judged against the permit already held
    assign try_prog = wr_ctl & bus_req.wdata[`NVB_CTL_PROG_GO];
    assign try_fetch = wr_ctl & bus_req.wdata[`NVB_CTL_FETCH_GO];
    // Both go bits at once is illegal; start neither
    assign start_write = try_prog & program_permit & ~try_fetch
        & (state == nvb_pkg::NVB_IDLE); // [RULE_06] [RULE_14]
    assign start_read = try_fetch & fetch_permit & ~try_prog
        & (state == nvb_pkg::NVB_IDLE); // [RULE_07] [RULE_14]

    assign read_done = (state == nvb_pkg::NVB_READ)
        & (read_cnt == 4'h0); // [RULE_26]
    assign write_done = (state == nvb_pkg::NVB_WRITE) & timer_done;

    always_comb begin
        next_state = state;
        case (state)
            nvb_pkg::NVB_IDLE: begin
                if (start_write) begin
                    next_state = nvb_pkg::NVB_WRITE;
                end else if (start_read) begin
                    next_state = nvb_pkg::NVB_READ;
                end
            end
            nvb_pkg::NVB_READ: begin
                if (read_done) begin
                    next_state = nvb_pkg::NVB_IDLE;
                end
            end
            nvb_pkg::NVB_WRITE: begin
                if (write_done) begin
                    next_state = nvb_pkg::NVB_IDLE;
                end
            end
            default: begin
                next_state = nvb_pkg::NVB_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= nvb_pkg::NVB_IDLE;
            nv_busy <= 1'b0;
        end else begin
            state <= next_state;
            nv_busy <= (next_state != nvb_pkg::NVB_IDLE);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            read_cnt <= 4'h0;
            rd_addr <= `NVB_RST_INDEX;
        end else if (start_read) begin
            read_cnt <= `NVB_READ_CYCLES - 4'h1; // [RULE_26]
            rd_addr <= nv_byte_index;
        end else if (read_cnt != 4'h0) begin
            read_cnt <= read_cnt - 4'h1;
        end
    end

    // Snapshot so software edits mid-cycle cannot corrupt the write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_addr <= `NVB_RST_INDEX;
            wr_data <= `NVB_RST_BYTE;
        end else if (start_write) begin
            wr_addr <= nv_byte_index; // [RULE_27]
            wr_data <= nv_byte_value; // [RULE_27]
        end
    end

    // Undefined after reset; zero chosen so nothing reads unknown
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nv_byte_index <= `NVB_RST_INDEX;
        end else if (wr_index) begin
            nv_byte_index <= bus_req.wdata[5:0]; // [RULE_02]
        end
    end

    // Read completion outranks a same-cycle software store
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nv_byte_value <= `NVB_RST_BYTE;
        end else if (read_done & fetch_permit) begin
            nv_byte_value <= store_rd_data; // [RULE_09] [RULE_11]
        end else if (wr_value) begin
            nv_byte_value <= bus_req.wdata; // [RULE_05] [RULE_12]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ram_bank_select <= 1'b0; // [RULE_18]
        end else if (wr_bank) begin
            ram_bank_select <= bus_req.wdata[`NVB_BANK_BIT]; // [RULE_24]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            program_permit <= 1'b0; // [RULE_04] [RULE_18]
            fetch_permit <= 1'b0; // [RULE_04]
        end else if (wr_ctl) begin
            program_permit <= bus_req.wdata[`NVB_CTL_PROG_PERMIT];
            fetch_permit <= bus_req.wdata[`NVB_CTL_FETCH_PERMIT];
        end
    end

    // Go bits only set by an accepted start; writing zero does nothing
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prog_go <= 1'b0; // [RULE_04]
        end else if (write_done) begin
            prog_go <= 1'b0; // [RULE_10]
        end else if (start_write) begin
            prog_go <= 1'b1; // [RULE_06]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fetch_go <= 1'b0; // [RULE_04]
        end else if (read_done) begin
            fetch_go <= 1'b0; // [RULE_11]
        end else if (start_read) begin
            fetch_go <= 1'b1; // [RULE_07]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nv_done_irq_mask <= 1'b0;
            mf_irq_enable <= 1'b0;
        end else if (wr_irq) begin
            nv_done_irq_mask <= bus_req.wdata[`NVB_IRQ_MASK];
            mf_irq_enable <= bus_req.wdata[`NVB_IRQ_MF_ENABLE];
        end
    end

    // Set wins over a same-cycle clear so no completion is lost
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nv_done_irq_flag <= 1'b0;
        end else if (write_done) begin
            nv_done_irq_flag <= 1'b1; // [RULE_19] [RULE_20]
        end else if (wr_irq & ~bus_req.wdata[`NVB_IRQ_FLAG]) begin
            nv_done_irq_flag <= 1'b0; // [RULE_22]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mf_irq_flag <= 1'b0;
        end else if (write_done) begin
            mf_irq_flag <= 1'b1; // [RULE_19] [RULE_20]
        end else if (irq_service) begin
            mf_irq_flag <= 1'b0; // [RULE_22]
        end else if (wr_irq & ~bus_req.wdata[`NVB_IRQ_MF_FLAG]) begin
            mf_irq_flag <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_vector_req <= 1'b0;
        end else begin
            irq_vector_req <= global_irq_gate & nv_done_irq_mask
                & mf_irq_enable & mf_irq_flag & ~stack_full; // [RULE_21]
        end
    end

    // Register read port, answered on the next edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_rdata <= 8'h00;
            bus_hit <= 1'b0;
        end else if (bus_req.rd) begin
            bus_hit <= sel_index | sel_value | sel_bank | sel_irq | sel_ctl;
            if (sel_index) begin
                bus_rdata <= {2'b00, nv_byte_index}; // [RULE_02]
            end else if (sel_value) begin
                bus_rdata <= nv_byte_value; // [RULE_05]
            end else if (sel_bank) begin
                bus_rdata <= {7'h00, ram_bank_select};
            end else if (sel_irq) begin
                bus_rdata <= {4'h0, mf_irq_flag, mf_irq_enable,
                    nv_done_irq_flag, nv_done_irq_mask};
            end else if (sel_ctl) begin
                bus_rdata <= {4'h0, program_permit, prog_go,
                    fetch_permit, fetch_go}; // [RULE_04]
            end else begin
                bus_rdata <= 8'h00;
            end
        end else begin
            bus_hit <= 1'b0;
            bus_rdata <= 8'h00;
        end
    end

    // Permit dropped mid-cycle still stops the byte landing
    assign store_req.wr_en = write_done & program_permit; // [RULE_08]
    assign store_req.wr_addr = wr_addr; // [RULE_01]
    assign store_req.wr_data = wr_data;
    assign store_req.rd_addr = rd_addr; // [RULE_01]

    nvb_store u_store (
        .ref_clk(ref_clk),
        .req(store_req),
        .rd_data(store_rd_data)
    );

    nvb_wtimer u_wtimer (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(start_write),
        .done(timer_done)
    );

endmodule : nvb_ctrl

// >>> nvb_ctrl_assertions.sv
// Checker for nvb_ctrl, bound to its ports.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/10ps
module nvb_ctrl_assertions (
    input wire logic ref_clk,
    input wire logic rst,
    input wire nvb_pkg::nvb_bus_req_t bus_req,
    input wire logic global_irq_gate,
    input wire logic stack_full,
    input wire logic irq_service,
    input wire logic [7:0] bus_rdata,
    input wire logic bus_hit,
    input wire logic irq_vector_req,
    input wire logic nv_busy
);
    // Write time is jittered, so only a band is checked
    localparam int WR_MIN = 99;
    localparam int WR_MAX = 118;
    logic [7:0] busy_len;
    logic mapped;
    logic is_ctl;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    assign is_ctl = bus_req.rd && bus_req.addr == 8'h40;
    assign mapped = (bus_req.addr inside {8'h04, 8'h0E, 8'h1E, 8'h1F})
        || bus_req.addr == 8'h40;
    always_ff @(posedge ref_clk) begin
        if (rst || !nv_busy) begin
            busy_len <= 8'h00;
        end else if (busy_len != 8'hFF) begin
            busy_len <= busy_len + 8'h01;
        end
    end
    a_unmapped_read_zero: assert property (bus_req.rd && !mapped |=>
        bus_rdata == 8'h00 && !bus_hit) else $error("unmapped read hit");
    a_direct_ctl_miss: assert property (is_ctl && !bus_req.indirect |=>
        !bus_hit && bus_rdata == 8'h00) else $error("direct control hit");
    a_index_top_zero: assert property (bus_req.rd &&
        bus_req.addr == 8'h1E |=> bus_hit && bus_rdata[7:6] == 2'b00)
        else $error("index upper bits set");
    a_ctl_top_zero: assert property (is_ctl |=>
        bus_rdata[7:4] == 4'h0) else $error("control upper bits set");
    a_cycle_length: assert property ($fell(nv_busy) |->
        busy_len == 8'h02 || (busy_len >= WR_MIN && busy_len <= WR_MAX))
        else $error("busy length wrong");
    a_busy_cause: assert property ($rose(nv_busy) |->
        $past(bus_req.wr) && $past(bus_req.addr) == 8'h40)
        else $error("busy without go write");
    a_vector_gated: assert property (irq_vector_req |->
        $past(global_irq_gate) && !$past(stack_full))
        else $error("vector while gated");
    a_hit_cause: assert property (bus_hit |-> $past(bus_req.rd))
        else $error("hit without read");
endmodule : nvb_ctrl_assertions

bind nvb_ctrl nvb_ctrl_assertions u_chk (
    .ref_clk(ref_clk),
    .rst(rst),
    .bus_req(bus_req),
    .global_irq_gate(global_irq_gate),
    .stack_full(stack_full),
    .irq_service(irq_service),
    .bus_rdata(bus_rdata),
    .bus_hit(bus_hit),
    .irq_vector_req(irq_vector_req),
    .nv_busy(nv_busy)
);

// >>> nvb_ctrl_tb.sv
// Self-checking bench for nvb_ctrl: registers, store write and read cycles, interrupt.
// Assumes the bound checker and the shipped write timer.
`timescale 1ns/10ps
module nvb_ctrl_tb;
    logic ref_clk;
    logic rst;
    nvb_pkg::nvb_bus_req_t bus_req;
    logic global_irq_gate;
    logic stack_full;
    logic irq_service;
    logic [7:0] bus_rdata;
    logic bus_hit;
    logic irq_vector_req;
    logic nv_busy;
    int bad_count;
    int cmp_count;
    logic [7:0] q;
    logic hit_q;

    nvb_ctrl dut (
        .ref_clk(ref_clk),
        .rst(rst),
        .bus_req(bus_req),
        .global_irq_gate(global_irq_gate),
        .stack_full(stack_full),
        .irq_service(irq_service),
        .bus_rdata(bus_rdata),
        .bus_hit(bus_hit),
        .irq_vector_req(irq_vector_req),
        .nv_busy(nv_busy)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic conclude;
        $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // One strobe cycle; read data sampled just after the answer edge
    task automatic acc(input logic [7:0] a, input logic [7:0] d,
        input logic w, input logic ind);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: ~w, indirect: ind};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
        bus_req.rd <= 1'b0;
        #1;
        q = bus_rdata;
        hit_q = bus_hit;
    endtask : acc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(a, d, 1'b1, 1'b0);
    endtask : wr

    task automatic cw(input logic [7:0] d);
        acc(8'h40, d, 1'b1, 1'b1);
    endtask : cw

    task automatic rdc(input logic [7:0] a, input logic ind,
        input logic [7:0] exp);
        acc(a, 8'h00, 1'b0, ind);
        chk(q, exp);
    endtask : rdc

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    // Bounded poll of a go bit
    task automatic wait_go(input int b);
        for (int n = 0; n < 300; n++) begin
            acc(8'h40, 8'h00, 1'b0, 1'b1);
            if (q[b] === 1'b0) begin
                return;
            end
        end
        bad_count++;
        conclude();
    endtask : wait_go

    task automatic t_regs;
        rdc(8'h04, 1'b0, 8'h00);
        wr(8'h04, 8'h01);
        rdc(8'h04, 1'b0, 8'h01);
        rdc(8'h40, 1'b1, 8'h00);
        cw(8'h02);
        rdc(8'h40, 1'b1, 8'h02);
        rdc(8'h40, 1'b0, 8'h00);
        chk({7'h00, hit_q}, 8'h00);
        wr(8'h04, 8'h00);
        rdc(8'h40, 1'b1, 8'h00);
        wr(8'h04, 8'h01);
        rdc(8'h55, 1'b0, 8'h00);
        chk({7'h00, hit_q}, 8'h00);
        wr(8'h1E, 8'hFF);
        rdc(8'h1E, 1'b0, 8'h3F);
        wr(8'h1F, 8'hA5);
        rdc(8'h1F, 1'b0, 8'hA5);
        chk({7'h00, hit_q}, 8'h01);
        cw(8'h00);
    endtask : t_regs

    task automatic t_write(input logic [7:0] i, input logic [7:0] v);
        wr(8'h1E, i);
        wr(8'h1F, v);
        global_irq_gate <= 1'b0;
        cw(8'h08);
        cw(8'h0C);
        chk({7'h00, nv_busy}, 8'h01);
        global_irq_gate <= 1'b1;
        // Disturb index and value mid-cycle
        wr(8'h1E, ~i);
        wr(8'h1F, ~v);
        rdc(8'h40, 1'b1, 8'h0C);
        wait_go(2);
        cw(8'h00);
    endtask : t_write

    task automatic t_read(input logic [7:0] i, input logic [7:0] v);
        cw(8'h02);
        wr(8'h1E, i);
        cw(8'h03);
        wait_go(0);
        rdc(8'h1F, 1'b0, v);
        tick(5);
        rdc(8'h1F, 1'b0, v);
        cw(8'h00);
    endtask : t_read

    task automatic t_refuse;
        wr(8'h1E, 8'h3F);
        wr(8'h1F, 8'h11);
        cw(8'h0C);
        // Permit bit itself is plain read/write, so it reads back set
        rdc(8'h40, 1'b1, 8'h08);
        chk({7'h00, nv_busy}, 8'h00);
        cw(8'h01);
        rdc(8'h40, 1'b1, 8'h00);
        rdc(8'h1F, 1'b0, 8'h11);
        cw(8'h0A);
        cw(8'h0F);
        rdc(8'h40, 1'b1, 8'h0A);
        cw(8'h00);
        t_read(8'h3F, 8'hC3);
    endtask : t_refuse

    task automatic t_irq;
        wr(8'h0E, 8'h05);
        t_write(8'h00, 8'h5A);
        chk({7'h00, irq_vector_req}, 8'h01);
        stack_full <= 1'b1;
        tick(2);
        chk({7'h00, irq_vector_req}, 8'h00);
        stack_full <= 1'b0;
        irq_service <= 1'b1;
        tick(1);
        irq_service <= 1'b0;
        tick(2);
        chk({7'h00, irq_vector_req}, 8'h00);
        rdc(8'h0E, 1'b0, 8'h07);
        wr(8'h0E, 8'h05);
        rdc(8'h0E, 1'b0, 8'h05);
        t_read(8'h00, 8'h5A);
    endtask : t_irq

    initial begin
        rst = 1'b1;
        bus_req = '0;
        global_irq_gate = 1'b0;
        stack_full = 1'b0;
        irq_service = 1'b0;
        bad_count = 0;
        cmp_count = 0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_write(8'h3F, 8'hC3);
        rdc(8'h0E, 1'b0, 8'h0A);
        wr(8'h0E, 8'h00);
        t_read(8'h3F, 8'hC3);
        rdc(8'h0E, 1'b0, 8'h00);
        t_refuse();
        t_irq();
        wr(8'h04, 8'h00);
        conclude();
    end
endmodule : nvb_ctrl_tb
